//--- hw/gpd_pkg.sv
/*
  Package for the GPIO port data path and configuration freeze block.
  Holds register offsets, field positions, reset values, bus carrier
  structs and the freeze-key state encoding. Assumes a 32-bit Wishbone bus.
*/
package gpd_pkg;
  // Register byte offsets
  localparam logic [7:0] GPD_OFS_PIN_INPUT_LEVELS = 8'h08;
  localparam logic [7:0] GPD_OFS_OUTPUT_LATCH = 8'h0c;
  localparam logic [7:0] GPD_OFS_ATOMIC_SET_CLEAR = 8'h10;
  localparam logic [7:0] GPD_OFS_ATOMIC_CLEAR_ONLY = 8'h14;
  localparam logic [7:0] GPD_OFS_CONFIG_FREEZE = 8'h18;
  localparam logic [7:0] GPD_OFS_PIN_CONFIG = 8'h00;
  // Field layout
  localparam int GPD_PINS = 16;
  localparam int GPD_CLEAR_LSB = 16;
  localparam int GPD_KEY_BIT = 16;
  localparam int GPD_CFG_W = 4 * GPD_PINS;
  // Reset values
  localparam logic [15:0] GPD_LATCH_RST = 16'h0000;
  localparam logic [15:0] GPD_FREEZE_RST = 16'h0000;
  localparam logic [31:0] GPD_PIN_CONFIG_RST = 32'h0000_0000;
  localparam logic [31:0] GPD_UNMAPPED_DATA = 32'h0000_0000;
  localparam logic [3:0] GPD_FULL_WORD = 4'hf;
  // Freeze-key sequence states
  typedef enum logic [2:0] {
    GPD_KEY_IDLE = 3'b000,
    GPD_KEY_W1 = 3'b001,
    GPD_KEY_W0 = 3'b010,
    GPD_KEY_W1B = 3'b011,
    GPD_KEY_R0 = 3'b100,
    GPD_KEY_DONE = 3'b101
  } gpd_key_e;
  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } gpd_wb_req_s;
  // Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } gpd_wb_rsp_s;
endpackage : gpd_pkg

//--- hw/gpd_port.sv
/*
  GPIO port data path: pin input sampling, output latch with atomic
  set/clear and clear-only writes, and the configuration freeze key.
  Assumes a classic Wishbone master on one 125 MHz clock and pins that
  are synchronous enough to sample through a two-stage synchroniser.
*/
// Register access over Wishbone was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RULE1: Input field follows sensed pin levels only
// RULE2: Input register at 0x08, upper half zero
// RULE3: Software uses full word accesses only
// RULE4: Output latch at 0x0C drives pins, resets zero
// RULE5: Set/clear register at 0x10 is write-only
// RULE6: Upper set/clear bits clear latch bits
// RULE7: Lower set/clear bits set latch bits
// RULE8: Zero bits leave latch bits unchanged
// RULE9: Clear-only register at 0x14 clears latch
// RULE10: Freeze register at 0x18, key bit 16
// RULE11: Reserved bits written as reset, ignored
// RULE12: Key sets after W1 W0 W1 R0 R1
// RULE13: Key set freezes flagged pins' configuration
// RULE14: Freeze bits held constant during key sequence
// RULE15: Set wins over clear in one write
// RULE16: Pin inputs pass two synchroniser flip-flops
module gpd_port
  import gpd_pkg::*;
(
  input wire logic clock,
  input wire logic rst_b,
  input wire gpd_wb_req_s wb_req,
  output gpd_wb_rsp_s wb_rsp,
  input wire logic [GPD_PINS-1:0] pin_in,
  output logic [GPD_PINS-1:0] pin_out,
  output logic [GPD_CFG_W-1:0] pin_config
);

  // Synchroniser stages for the pins
  logic [GPD_PINS-1:0] sync1_reg;
  logic [GPD_PINS-1:0] sync2_reg;
  // Output latch and freeze state
  logic [GPD_PINS-1:0] out_latch_bit_reg;
  logic [GPD_PINS-1:0] out_latch_bit_next;
  logic [GPD_PINS-1:0] pin_freeze_bit_reg;
  logic [GPD_PINS-1:0] pin_freeze_bit_next;
  logic freeze_key_flag_reg;
  logic freeze_key_flag_next;
  gpd_key_e key_state_reg;
  gpd_key_e key_state_next;
  logic [GPD_PINS-1:0] key_freeze_val_reg;
  logic [GPD_PINS-1:0] key_freeze_val_next;
  // Per-pin mode/configuration, 4 bits a pin, two words
  logic [GPD_CFG_W-1:0] cfg_reg;
  logic [GPD_CFG_W-1:0] cfg_next;
  // Bus answer state
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  // Access qualifiers
  logic access;
  logic wr;
  logic rd;

  // Offset match on word address adr[7:2] only; the full word check is made in wr
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // Merge a word into the 8 pin configurations it covers, honouring freeze
  function automatic logic [GPD_CFG_W-1:0] cfg_merge(
    input logic [GPD_CFG_W-1:0] cur,
    input logic [31:0] wd,
    input logic hi,
    input logic [GPD_PINS-1:0] locked);
    logic [GPD_CFG_W-1:0] res;
    int base;
    res = cur;
    base = hi ? 32 : 0;
    for (int p = 0; p < 8; p++) begin
      if (!locked[p + (hi ? 8 : 0)]) begin
        res[base + 4*p +: 4] = wd[4*p +: 4]; // [RULE13]
      end
    end
    cfg_merge = res;
  endfunction

  // A new request is a strobe with no answer pending
  assign access = wb_req.cyc && wb_req.stb && !ack_reg;
  // Word writes only; partial-lane writes are acknowledged but ignored, reads ignore sel
  assign wr = access && wb_req.we && (wb_req.sel == GPD_FULL_WORD); // [RULE3]
  assign rd = access && !wb_req.we;

  // Two-stage pin synchroniser; only stage two is ever read
  // Limitation: a pin pulse shorter than one clock may be missed entirely
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      sync1_reg <= GPD_LATCH_RST;
      sync2_reg <= GPD_LATCH_RST;
    end else begin
      sync1_reg <= pin_in; // [RULE16]
      sync2_reg <= sync1_reg; // [RULE1]
    end
  end

  // Next-state logic for latch, configuration and freeze key
  always_comb begin
    out_latch_bit_next = out_latch_bit_reg;
    pin_freeze_bit_next = pin_freeze_bit_reg;
    freeze_key_flag_next = freeze_key_flag_reg;
    key_state_next = key_state_reg;
    key_freeze_val_next = key_freeze_val_reg;
    cfg_next = cfg_reg;
    if (wr && hit(wb_req.adr, GPD_OFS_OUTPUT_LATCH)) begin
      // Plain write; reserved upper half is dropped
      out_latch_bit_next = wb_req.dat[GPD_PINS-1:0]; // [RULE4] [RULE11]
    end
    if (wr && hit(wb_req.adr, GPD_OFS_ATOMIC_SET_CLEAR)) begin
      // Clear first, then set, so set wins on the same pin
      out_latch_bit_next = (out_latch_bit_reg
        & ~wb_req.dat[GPD_CLEAR_LSB +: GPD_PINS]) // [RULE6] [RULE8]
        | wb_req.dat[GPD_PINS-1:0]; // [RULE7] [RULE15]
    end
    if (wr && hit(wb_req.adr, GPD_OFS_ATOMIC_CLEAR_ONLY)) begin
      out_latch_bit_next = out_latch_bit_reg & ~wb_req.dat[GPD_PINS-1:0]; // [RULE9] [RULE8]
    end
    if (wr && hit(wb_req.adr, GPD_OFS_PIN_CONFIG)) begin
      cfg_next = cfg_merge(cfg_reg, wb_req.dat, 1'b0,
        freeze_key_flag_reg ? pin_freeze_bit_reg : GPD_FREEZE_RST); // [RULE13]
    end
    if (wr && hit(wb_req.adr, GPD_OFS_PIN_CONFIG + 8'h04)) begin
      cfg_next = cfg_merge(cfg_reg, wb_req.dat, 1'b1,
        freeze_key_flag_reg ? pin_freeze_bit_reg : GPD_FREEZE_RST); // [RULE13]
    end
    // Freeze register: once the key is set nothing here changes until reset
    // A read that does not close the sequence throws it away, so software
    // that polls the register between key writes has to start again
    if (!freeze_key_flag_reg && hit(wb_req.adr, GPD_OFS_CONFIG_FREEZE)) begin
      if (wr) begin
        pin_freeze_bit_next = wb_req.dat[GPD_PINS-1:0];
        // Key sequence: any break or changed freeze bits restarts it
        case (key_state_reg)
          GPD_KEY_IDLE, GPD_KEY_W0, GPD_KEY_W1B, GPD_KEY_R0, GPD_KEY_DONE,
          GPD_KEY_W1: begin
            if (wb_req.dat[GPD_KEY_BIT]) begin
              if (key_state_reg == GPD_KEY_W0
                  && wb_req.dat[GPD_PINS-1:0] == key_freeze_val_reg) begin
                key_state_next = GPD_KEY_W1B; // [RULE12] [RULE14]
              end else begin
                key_state_next = GPD_KEY_W1;
              end
            end else if (key_state_reg == GPD_KEY_W1
                && wb_req.dat[GPD_PINS-1:0] == key_freeze_val_reg) begin
              key_state_next = GPD_KEY_W0; // [RULE12] [RULE14]
            end else begin
              key_state_next = GPD_KEY_IDLE;
            end
            key_freeze_val_next = wb_req.dat[GPD_PINS-1:0];
          end
          default: begin
            key_state_next = GPD_KEY_IDLE;
          end
        endcase
      end else if (rd) begin
        case (key_state_reg)
          GPD_KEY_W1B: begin
            // First read returns 0, flag goes high after it
            key_state_next = GPD_KEY_R0;
            freeze_key_flag_next = 1'b1; // [RULE12]
          end
          default: begin
            key_state_next = GPD_KEY_IDLE;
          end
        endcase
      end
    end
  end

  // State registers; the freeze key flag is cleared only by reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      out_latch_bit_reg <= GPD_LATCH_RST; // [RULE4]
      pin_freeze_bit_reg <= GPD_FREEZE_RST; // [RULE10]
      freeze_key_flag_reg <= 1'b0; // [RULE10]
      key_state_reg <= GPD_KEY_IDLE;
      key_freeze_val_reg <= GPD_FREEZE_RST;
      cfg_reg <= {2{GPD_PIN_CONFIG_RST}};
    end else begin
      out_latch_bit_reg <= out_latch_bit_next;
      pin_freeze_bit_reg <= pin_freeze_bit_next;
      freeze_key_flag_reg <= freeze_key_flag_next;
      key_state_reg <= key_state_next;
      key_freeze_val_reg <= key_freeze_val_next;
      cfg_reg <= cfg_next;
    end
  end

  // Bus answer: ack one cycle after the strobe, dropped the next cycle
  // Trade-off: every access costs two cycles, but read data comes from a
  // flip-flop and the read mux never sits on the bus path in that cycle
  always_comb begin
    ack_next = access;
    rdata_next = GPD_UNMAPPED_DATA;
    if (rd) begin
      if (hit(wb_req.adr, GPD_OFS_PIN_INPUT_LEVELS)) begin
        rdata_next = {16'h0000, sync2_reg}; // [RULE2] [RULE1]
      end else if (hit(wb_req.adr, GPD_OFS_OUTPUT_LATCH)) begin
        rdata_next = {16'h0000, out_latch_bit_reg}; // [RULE4]
      end else if (hit(wb_req.adr, GPD_OFS_CONFIG_FREEZE)) begin
        rdata_next = {15'h0000, freeze_key_flag_reg, pin_freeze_bit_reg}; // [RULE10]
      end else if (hit(wb_req.adr, GPD_OFS_PIN_CONFIG)) begin
        rdata_next = cfg_reg[31:0];
      end else if (hit(wb_req.adr, GPD_OFS_PIN_CONFIG + 8'h04)) begin
        rdata_next = cfg_reg[63:32];
      end else begin
        // Write-only and unmapped words read zero
        rdata_next = GPD_UNMAPPED_DATA; // [RULE5]
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ack_reg <= 1'b0;
      rdata_reg <= GPD_UNMAPPED_DATA;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end

  assign wb_rsp.ack = ack_reg;
  assign wb_rsp.dat = rdata_reg;
  assign pin_out = out_latch_bit_reg; // [RULE4]
  assign pin_config = cfg_reg;

  // Checks
  // All properties are gated by reset, so the first edges after release
  // see only registered state and no stale request
  // A full-word latch write shows on the pins one edge later
  latch_drives_pin_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE4]
    (wr && hit(wb_req.adr, GPD_OFS_OUTPUT_LATCH))
    |=> (pin_out == $past(wb_req.dat[GPD_PINS-1:0])))
    else $error("pin drive differs from written latch value");
  set_wins_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE15]
    (wr && hit(wb_req.adr, GPD_OFS_ATOMIC_SET_CLEAR))
    |=> ((out_latch_bit_reg & $past(wb_req.dat[15:0])) == $past(wb_req.dat[15:0])))
    else $error("set request not applied");
  clear_applies_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE9]
    (wr && hit(wb_req.adr, GPD_OFS_ATOMIC_CLEAR_ONLY))
    |=> ((out_latch_bit_reg & $past(wb_req.dat[15:0])) == 16'h0000))
    else $error("clear-only request not applied");
  clear_half_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE6]
    (wr && hit(wb_req.adr, GPD_OFS_ATOMIC_SET_CLEAR))
    |=> ((out_latch_bit_reg & $past(wb_req.dat[31:16]) & ~$past(wb_req.dat[15:0]))
      == 16'h0000)) else $error("clear half not applied");
  sync_delay_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE16]
    ##2 (sync2_reg == $past(pin_in, 2))) else $error("pin sync delay wrong");
  key_sticky_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE12]
    freeze_key_flag_reg |=> freeze_key_flag_reg) else $error("freeze key dropped");
  key_cause_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE12]
    $rose(freeze_key_flag_reg) |-> $past(key_state_reg) == GPD_KEY_W1B)
    else $error("freeze key set without sequence");
  freeze_holds_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE13]
    freeze_key_flag_reg |=> $stable(pin_freeze_bit_reg)) else $error("freeze bits moved");
  ack_pulse_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE2]
    ack_reg |=> !ack_reg) else $error("ack held two cycles");
  upper_zero_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE2]
    (rd && hit(wb_req.adr, GPD_OFS_PIN_INPUT_LEVELS))
    |=> (rdata_reg == {16'h0000, $past(sync2_reg)}))
    else $error("input register read wrong");
  // Zero positions of a clear-only write must leave their latch bits alone
  clear_keeps_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE8]
    (wr && hit(wb_req.adr, GPD_OFS_ATOMIC_CLEAR_ONLY))
    |=> (((out_latch_bit_reg ^ $past(out_latch_bit_reg))
      & ~$past(wb_req.dat[GPD_PINS-1:0])) == 16'h0000))
    else $error("clear-only write disturbed other bits");
  // Byte or halfword writes are acknowledged but must leave the latch and configuration unchanged
  partial_refused_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE3]
    (access && wb_req.we && (wb_req.sel != GPD_FULL_WORD))
    |=> ($stable(out_latch_bit_reg) && $stable(cfg_reg)))
    else $error("partial write changed state");
  // Frozen pin 0 keeps its configuration nibble through a low-word config write
  frozen_cfg_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE13]
    (wr && hit(wb_req.adr, GPD_OFS_PIN_CONFIG)
      && freeze_key_flag_reg && pin_freeze_bit_reg[0])
    |=> $stable(cfg_reg[3:0]))
    else $error("frozen pin configuration changed");
  // The key can only rise on the read that closes the sequence
  key_on_read_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE12]
    $rose(freeze_key_flag_reg) |-> $past(rd))
    else $error("freeze key set without a read");
  // Every request, mapped or not, is answered on the next edge
  ack_follows_a: assert property (@(posedge clock) disable iff (!rst_b) // [RULE2]
    access |=> ack_reg) else $error("request not acknowledged");
  set_clear_c: cover property (@(posedge clock) disable iff (!rst_b)
    wr && hit(wb_req.adr, GPD_OFS_ATOMIC_SET_CLEAR));
  clear_only_c: cover property (@(posedge clock) disable iff (!rst_b)
    wr && hit(wb_req.adr, GPD_OFS_ATOMIC_CLEAR_ONLY));
  key_set_c: cover property (@(posedge clock) disable iff (!rst_b)
    $rose(freeze_key_flag_reg));
  partial_write_c: cover property (@(posedge clock) disable iff (!rst_b)
    access && wb_req.we && (wb_req.sel != GPD_FULL_WORD));
  frozen_write_c: cover property (@(posedge clock) disable iff (!rst_b)
    wr && hit(wb_req.adr, GPD_OFS_PIN_CONFIG) && freeze_key_flag_reg);

endmodule // gpd_port
`default_nettype wire

//--- verification/gpd_pin_model.sv
/*
  Model of the outside world at the port pins: loops the output latch
  back onto the inputs, or drives a level chosen by the bench.
  Assumes one system clock; levels change only after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module gpd_pin_model
  import gpd_pkg::*;
(
  input wire logic clock,
  input wire logic [GPD_PINS-1:0] pin_out,
  input wire logic ext_en,
  input wire logic [GPD_PINS-1:0] ext_lvl,
  output var logic [GPD_PINS-1:0] pin_in
);
  // Unknown only for the first edge, while the block is still in reset
  // Outside source wins over loopback; one edge of delay like a real pad
  always @(posedge clock) begin
    pin_in <= ext_en ? ext_lvl : pin_out;
  end
endmodule // gpd_pin_model
`default_nettype wire

//--- verification/tb_gpd_port.sv
/*
  Self-checking testbench for the port data path: latch, atomic writes,
  pin sampling and the freeze key, all through Wishbone tasks.
  Assumes the pin model loops outputs back unless the bench overrides.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_gpd_port;
  import gpd_pkg::*;
  logic clock = 1'b0; // 125 MHz system clock
  logic rst_b = 1'b0; // Active-low reset
  gpd_wb_req_s req = '0; // Bus request from the bench
  gpd_wb_rsp_s rsp; // Bus answer
  logic [GPD_PINS-1:0] pin_in, pin_out;
  logic [GPD_PINS-1:0] ext_lvl = '0; // Level forced onto the pins
  logic ext_en = 1'b0; // Outside source drives the pins
  logic [GPD_CFG_W-1:0] pin_config;
  logic [31:0] q; // Last read data
  int error_cnt = 0;
  int checked = 0;
  // Half period of 4 ns
  always #4 clock = ~clock;
  gpd_port gpd_port_inst (.clock(clock), .rst_b(rst_b), .wb_req(req), .wb_rsp(rsp),
    .pin_in(pin_in), .pin_out(pin_out), .pin_config(pin_config));
  gpd_pin_model gpd_pin_model_inst (.clock(clock), .pin_out(pin_out), .ext_en(ext_en),
    .ext_lvl(ext_lvl), .pin_in(pin_in));
  // Single verdict point; a bus timeout also ends up here
  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Compare with case equality so unknowns never match
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (10) @(posedge clock);
    rst_b <= 1'b1;
  endtask
  // Classic cycle: hold everything until ack is sampled, then release
  task automatic bus(input logic we, input logic [7:0] a, input logic [3:0] s,
    input logic [31:0] d);
    int n = 0;
    @(posedge clock);
    req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: s, dat: d};
    do begin
      @(posedge clock);
      n++;
    end while (rsp.ack !== 1'b1 && n < 50);
    q = rsp.dat;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
    if (n >= 50) begin
      error_cnt++;
      $display("CHECK FAILED ack timeout at %h", a);
      end_of_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, GPD_FULL_WORD, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, GPD_FULL_WORD, 32'h0000_0000);
  endtask
  task automatic t_reset();
    check("pin out rst", {16'h0000, pin_out}, 32'h0000_0000);
    rd(GPD_OFS_OUTPUT_LATCH); check("latch rst", q, 32'h0000_0000);
    rd(GPD_OFS_CONFIG_FREEZE); check("freeze rst", q, 32'h0000_0000);
    rd(8'h20); check("unmapped", q, GPD_UNMAPPED_DATA);
  endtask
  // Latch write, atomic set/clear, set priority, clear-only, byte write
  task automatic t_latch();
    wr(GPD_OFS_OUTPUT_LATCH, 32'h0000_a5c3);
    rd(GPD_OFS_OUTPUT_LATCH); check("latch", q, 32'h0000_a5c3);
    check("pin out", {16'h0000, pin_out}, 32'h0000_a5c3);
    wr(GPD_OFS_ATOMIC_SET_CLEAR, 32'h00f0_000f);
    check("set clear", {16'h0000, pin_out}, 32'h0000_a50f);
    rd(GPD_OFS_ATOMIC_SET_CLEAR); check("setclr read", q, 32'h0000_0000);
    wr(GPD_OFS_ATOMIC_SET_CLEAR, 32'h0003_0001);
    check("set wins", {16'h0000, pin_out}, 32'h0000_a50d);
    wr(GPD_OFS_ATOMIC_CLEAR_ONLY, 32'h0000_0500);
    check("clear only", {16'h0000, pin_out}, 32'h0000_a00d);
    rd(GPD_OFS_ATOMIC_CLEAR_ONLY); check("clr read", q, 32'h0000_0000);
    bus(1'b1, GPD_OFS_OUTPUT_LATCH, 4'h1, 32'h0000_0000);
    check("byte write", {16'h0000, pin_out}, 32'h0000_a00d);
  endtask
  // Pins are seen only after the synchroniser; writes cannot touch them
  task automatic t_input();
    ext_en <= 1'b1;
    ext_lvl <= 16'h3c5a;
    repeat (4) @(posedge clock);
    rd(GPD_OFS_PIN_INPUT_LEVELS); check("pins", q, 32'h0000_3c5a);
    wr(GPD_OFS_PIN_INPUT_LEVELS, 32'h0000_ffff);
    rd(GPD_OFS_PIN_INPUT_LEVELS); check("pins ro", q, 32'h0000_3c5a);
    ext_lvl <= 16'hc3a5;
    rd(GPD_OFS_PIN_INPUT_LEVELS); check("pins early", q, 32'h0000_3c5a);
    repeat (4) @(posedge clock);
    rd(GPD_OFS_PIN_INPUT_LEVELS); check("pins 2", q, 32'h0000_c3a5);
    ext_en <= 1'b0;
  endtask
  // Freeze bits stay 0x0003 on every key write
  task automatic t_lock();
    wr(GPD_OFS_PIN_CONFIG, 32'h1111_1111);
    wr(GPD_OFS_PIN_CONFIG + 8'h04, 32'h3333_3333);
    check("cfg lo", pin_config[31:0], 32'h1111_1111);
    check("cfg hi", pin_config[63:32], 32'h3333_3333);
    wr(GPD_OFS_CONFIG_FREEZE, 32'h0001_0003);
    rd(GPD_OFS_CONFIG_FREEZE); check("key early", q, 32'h0000_0003);
    wr(GPD_OFS_CONFIG_FREEZE, 32'h0001_0003);
    wr(GPD_OFS_CONFIG_FREEZE, 32'h0000_0003);
    wr(GPD_OFS_CONFIG_FREEZE, 32'h0001_0003);
    rd(GPD_OFS_CONFIG_FREEZE); check("key read0", q, 32'h0000_0003);
    rd(GPD_OFS_CONFIG_FREEZE); check("key read1", q, 32'h0001_0003);
    wr(GPD_OFS_PIN_CONFIG, 32'h2222_2222);
    check("frozen cfg", pin_config[31:0], 32'h2222_2211);
    wr(GPD_OFS_PIN_CONFIG + 8'h04, 32'h4444_4444);
    check("unfrozen cfg", pin_config[63:32], 32'h4444_4444);
    rd(GPD_OFS_PIN_CONFIG); check("cfg read", q, 32'h2222_2211);
    wr(GPD_OFS_CONFIG_FREEZE, 32'h0000_0000);
    rd(GPD_OFS_CONFIG_FREEZE); check("key held", q, 32'h0001_0003);
  endtask
  initial begin
    do_reset();
    t_reset();
    t_latch();
    t_input();
    t_lock();
    do_reset();
    rd(GPD_OFS_CONFIG_FREEZE); check("key cleared", q, 32'h0000_0000);
    end_of_test();
  end
endmodule // tb_gpd_port
`default_nettype wire
